/* File: hdl/iox_map.svh */
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

// Fixed upper nibble of the responder address
`define IOX_ADDR_FIXED    4'h7
// Port latch value after reset: every pin high on the weak pullup
`define IOX_LATCH_RESET   8'hff
// Data bits in one byte, counted by the bit counter
`define IOX_BYTE_BITS     4'h8
// Synchroniser reset: bus lines idle high, pins high, address straps 3'b001
`define IOX_SYNC_RESET    13'h07ff

`endif

/* File: hdl/iox_pkg.sv */
package iox_pkg;

  typedef enum logic [2:0] {
    IOX_IDLE,
    IOX_ADDR,
    IOX_ADDR_ACK,
    IOX_WR_DATA,
    IOX_WR_ACK,
    IOX_RD_DATA,
    IOX_RD_ACK,
    IOX_IGNORE
  } iox_state_type;

  typedef logic [7:0] iox_byte_type;

endpackage

/* File: hdl/iox_alert_if.sv */
`timescale 1ns/1ns
interface iox_alert_if;
  logic [7:0] pinLevel;
  logic [7:0] inputMask;
  logic       clearReq;
  logic [7:0] clearValue;
  logic       alertActive;

  modport core (
    output pinLevel,
    output inputMask,
    output clearReq,
    output clearValue,
    input  alertActive
  );

  modport alert (
    input  pinLevel,
    input  inputMask,
    input  clearReq,
    input  clearValue,
    output alertActive
  );
endinterface

/* File: hdl/iox_sync.sv */
`timescale 1ns/1ns
module iox_sync #(
  parameter int                 WIDTH     = 13,
  parameter logic [WIDTH-1:0]   RESET_VAL = '1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Asynchronous inputs and their filtered levels
  input  wire logic [WIDTH-1:0] rawIn,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // A bit only moves once stages two and three agree, so a one-cycle
  // glitch that slips past the second flop never reaches the core.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      assign level_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : level_reg[i];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
      level_reg  <= RESET_VAL;
    end else begin
      stage1_reg <= rawIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg  <= level_next;
    end
  end

  assign level = level_reg;

endmodule

/* File: hdl/iox_change_alert.sv */
`timescale 1ns/1ns
`include "iox_map.svh"
module iox_change_alert
  import iox_pkg::*;
(
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst,
  // Link to the bus core
  iox_alert_if.alert al
);

  iox_byte_type refLevel_reg;
  iox_byte_type refLevel_next;
  logic         active_reg;
  logic         active_next;

  always_comb begin
    refLevel_next = refLevel_reg;
    active_next   = active_reg;
    if (al.clearReq) begin
      // Re-arm against clearValue: the byte sent on a read, the pin level at the write acknowledge; detection resumes next edge
      refLevel_next = al.clearValue;
      active_next   = 1'b0;
    end else begin
      // Level compare: returning to the reference clears by itself
      active_next = |((al.pinLevel ^ refLevel_reg) & al.inputMask);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      refLevel_reg <= `IOX_LATCH_RESET;
      active_reg   <= 1'b0;
    end else begin
      refLevel_reg <= refLevel_next;
      active_reg   <= active_next;
    end
  end

  assign al.alertActive = active_reg;

endmodule

/* File: hdl/iox_expander.sv */
`timescale 1ns/1ns
`include "iox_map.svh"
module iox_expander
  import iox_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // I2C bus, open drain
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Address straps
  input  wire logic [2:0] pinAddressSelect,
  // Quasi-bidirectional port
  input  wire logic [7:0] expanderPinIn,
  output logic      [7:0] expanderPinOut,
  output logic      [7:0] expanderPinOe,
  output logic      [7:0] expanderPinStrongUp,
  // Change alert, open drain, active low
  output logic            alertOut,
  output logic            alertOe
);

  iox_alert_if alertLink ();

  logic [12:0]   syncLevel;
  logic          sclLevel;
  logic          sdaLevel;
  logic [2:0]    addrLevel;
  iox_byte_type  pinLevel;

  logic          sclPrev_reg;
  logic          sdaPrev_reg;
  logic          sclRise;
  logic          sclFall;
  logic          startSeen;
  logic          stopSeen;
  logic          addrMatch;

  iox_state_type state_reg;
  iox_state_type state_next;
  logic [3:0]    bitCnt_reg;
  logic [3:0]    bitCnt_next;
  iox_byte_type  rxShift_reg;
  iox_byte_type  rxShift_next;
  iox_byte_type  txShift_reg;
  iox_byte_type  txShift_next;
  iox_byte_type  txShifted;
  iox_byte_type  readSnap_reg;
  iox_byte_type  readSnap_next;
  logic          readMode_reg;
  logic          readMode_next;
  logic          sdaOe_reg;
  logic          sdaOe_next;
  iox_byte_type  latch_reg;
  iox_byte_type  latch_next;
  iox_byte_type  pinOe_reg;
  iox_byte_type  pinOe_next;
  iox_byte_type  strong_reg;
  iox_byte_type  strong_next;
  logic          clear_reg;
  logic          clear_next;
  iox_byte_type  clearValue_reg;
  iox_byte_type  clearValue_next;
  logic          lowLevel_reg;

  // Bus lines, pins and straps all come from outside this clock
  iox_sync #(
    .WIDTH     (13),
    .RESET_VAL (`IOX_SYNC_RESET)
  ) uSync (
    .mclk  (mclk),
    .rst   (rst),
    .rawIn ({pinAddressSelect, expanderPinIn, sdaIn, sclIn}),
    .level (syncLevel)
  );

  assign sclLevel  = syncLevel[0];
  assign sdaLevel  = syncLevel[1];
  assign pinLevel  = syncLevel[9:2];
  assign addrLevel = syncLevel[12:10];

  // Edge history of the filtered bus lines
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclLevel;
      sdaPrev_reg <= sdaLevel;
    end
  end

  assign sclRise   = sclLevel & ~sclPrev_reg;
  assign sclFall   = ~sclLevel & sclPrev_reg;
  assign startSeen = sclLevel & sclPrev_reg & sdaPrev_reg & ~sdaLevel;
  assign stopSeen  = sclLevel & sclPrev_reg & ~sdaPrev_reg & sdaLevel;

  // The general call byte has a zero upper nibble, so it never matches
  assign addrMatch = (rxShift_reg[7:4] == `IOX_ADDR_FIXED) && (rxShift_reg[3:1] == addrLevel);

  assign txShifted = {txShift_reg[6:0], 1'b1};

  always_comb begin
    state_next      = state_reg;
    bitCnt_next     = bitCnt_reg;
    rxShift_next    = rxShift_reg;
    txShift_next    = txShift_reg;
    readSnap_next   = readSnap_reg;
    readMode_next   = readMode_reg;
    sdaOe_next      = sdaOe_reg;
    latch_next      = latch_reg;
    strong_next     = strong_reg;
    clear_next      = 1'b0;
    clearValue_next = clearValue_reg;
    if (sclFall) begin
      strong_next = '0;
    end
    if (startSeen) begin
      // Repeated start is handled the same way as a first start
      state_next  = IOX_ADDR;
      bitCnt_next = '0;
      sdaOe_next  = 1'b0;
    end else if (stopSeen) begin
      // Shift contents are abandoned; latches keep the last acknowledged byte
      state_next  = IOX_IDLE;
      bitCnt_next = '0;
      sdaOe_next  = 1'b0;
    end else begin
      case (state_reg)
        IOX_ADDR: begin
          if (sclRise) begin
            rxShift_next = {rxShift_reg[6:0], sdaLevel};
            bitCnt_next  = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == `IOX_BYTE_BITS) begin
            bitCnt_next   = '0;
            readMode_next = rxShift_reg[0];
            if (addrMatch) begin
              state_next = IOX_ADDR_ACK;
              sdaOe_next = 1'b1;
            end else begin
              // Not ours: no acknowledge and no alert side effects
              state_next = IOX_IGNORE;
            end
          end
        end
        IOX_ADDR_ACK: begin
          if (sclRise && readMode_reg) begin
            txShift_next  = pinLevel;
            readSnap_next = pinLevel;
          end else if (sclFall) begin
            if (readMode_reg) begin
              state_next = IOX_RD_DATA;
              sdaOe_next = ~txShift_reg[7];
            end else begin
              state_next = IOX_WR_DATA;
              sdaOe_next = 1'b0;
            end
          end
        end
        IOX_RD_DATA: begin
          if (sclRise) begin
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_reg == `IOX_BYTE_BITS) begin
              state_next = IOX_RD_ACK;
              sdaOe_next = 1'b0;
            end else begin
              txShift_next = txShifted;
              sdaOe_next   = ~txShifted[7];
            end
          end
        end
        IOX_RD_ACK: begin
          if (sclRise) begin
            // Reference is the byte sent, so a change since the sample re-alerts
            clear_next      = 1'b1;
            clearValue_next = readSnap_reg;
          end else if (sclFall) begin
            state_next = IOX_IGNORE;
          end
        end
        IOX_WR_DATA: begin
          if (sclRise) begin
            rxShift_next = {rxShift_reg[6:0], sdaLevel};
            bitCnt_next  = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == `IOX_BYTE_BITS) begin
            state_next = IOX_WR_ACK;
            sdaOe_next = 1'b1;
          end
        end
        IOX_WR_ACK: begin
          if (sclRise) begin
            latch_next      = rxShift_reg;
            strong_next     = rxShift_reg;
            clear_next      = 1'b1;
            clearValue_next = pinLevel;
          end else if (sclFall) begin
            state_next = IOX_IGNORE;
            sdaOe_next = 1'b0;
          end
        end
        default: begin
          // Idle and ignore: wait for start or stop, SDA released
          sdaOe_next = 1'b0;
        end
      endcase
    end
    // Low latch bits drive the pin hard; high bits rest on the weak pullup
    pinOe_next = ~latch_next;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg      <= IOX_IDLE;
      bitCnt_reg     <= '0;
      rxShift_reg    <= '0;
      txShift_reg    <= '0;
      readSnap_reg   <= `IOX_LATCH_RESET;
      readMode_reg   <= 1'b0;
      sdaOe_reg      <= 1'b0;
      latch_reg      <= `IOX_LATCH_RESET;
      pinOe_reg      <= '0;
      strong_reg     <= '0;
      clear_reg      <= 1'b0;
      clearValue_reg <= `IOX_LATCH_RESET;
      lowLevel_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      bitCnt_reg     <= bitCnt_next;
      rxShift_reg    <= rxShift_next;
      txShift_reg    <= txShift_next;
      readSnap_reg   <= readSnap_next;
      readMode_reg   <= readMode_next;
      sdaOe_reg      <= sdaOe_next;
      latch_reg      <= latch_next;
      pinOe_reg      <= pinOe_next;
      strong_reg     <= strong_next;
      clear_reg      <= clear_next;
      clearValue_reg <= clearValue_next;
      lowLevel_reg   <= 1'b0;
    end
  end

  // Only pins resting high can be inputs, so only they raise alerts
  assign alertLink.pinLevel   = pinLevel;
  assign alertLink.inputMask  = latch_reg;
  assign alertLink.clearReq   = clear_reg;
  assign alertLink.clearValue = clearValue_reg;

  iox_change_alert uAlert (
    .mclk (mclk),
    .rst  (rst),
    .al   (alertLink.alert)
  );

  assign sdaOut              = lowLevel_reg;
  assign sdaOe               = sdaOe_reg;
  assign expanderPinOut      = latch_reg;
  assign expanderPinOe       = pinOe_reg;
  assign expanderPinStrongUp = strong_reg;
  assign alertOut            = lowLevel_reg;
  assign alertOe             = alertLink.alertActive;

endmodule

/* File: bench/iox_expander_checker.sv */
`timescale 1ns/1ns
module iox_expander_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Bus and port
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [7:0] expanderPinIn,
  input wire logic [7:0] expanderPinOut,
  input wire logic [7:0] expanderPinOe,
  input wire logic [7:0] expanderPinStrongUp,
  input wire logic       alertOut,
  input wire logic       alertOe
);
  logic [3:0] sinceFall;
  logic [3:0] sinceRise;
  logic [3:0] sincePin;
  logic       sclPrev;
  logic [7:0] pinPrev;
  // Saturating ages of the last SCL edges and pin change
  always_ff @(posedge mclk) begin
    sclPrev <= sclIn;
    pinPrev <= expanderPinIn;
    if (rst) begin
      sinceFall <= 4'hf;
      sinceRise <= 4'hf;
      sincePin  <= 4'hf;
    end else begin
      sinceFall <= (sclPrev & ~sclIn) ? 4'h0 : sinceFall + {3'h0, sinceFall != 4'hf};
      sinceRise <= (~sclPrev & sclIn) ? 4'h0 : sinceRise + {3'h0, sinceRise != 4'hf};
      sincePin  <= (pinPrev != expanderPinIn) ? 4'h0 : sincePin + {3'h0, sincePin != 4'hf};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reset_state_a:
    assert property (disable iff (1'b0) rst |=> expanderPinOut == 8'hff && expanderPinOe == 8'h00
      && expanderPinStrongUp == 8'h00 && !alertOe && !sdaOe) else $error("bad state after reset");
  open_drain_a:
    assert property (!sdaOut && !alertOut) else $error("open-drain data driven high");
  pin_drive_a:
    assert property (expanderPinOe == ~expanderPinOut) else $error("pin drive not latch inverse");
  strong_high_a:
    assert property ((expanderPinStrongUp & ~expanderPinOut) == 8'h00) else $error("strong pullup on low pin");
  strong_off_a:
    assert property ($rose(|expanderPinStrongUp) |-> ##[1:12] expanderPinStrongUp == 8'h00)
      else $error("strong pullup not released");
  latch_strong_a:
    assert property ($changed(expanderPinOut) |-> expanderPinStrongUp == expanderPinOut)
      else $error("latch update without strong pullup");
  sda_timing_a:
    assert property ($changed(sdaOe) |-> sinceFall inside {[3:8]}) else $error("data line moved off SCL low");
  alert_rise_a:
    assert property ($rose(alertOe) |-> sincePin <= 4'h9) else $error("alert without pin change");
  alert_fall_a:
    assert property ($fell(alertOe) |-> sincePin <= 4'ha || sinceRise <= 4'ha) else $error("alert cleared uncaused");
endmodule

bind iox_expander iox_expander_checker chk (.*);

/* File: bench/iox_commander.sv */
`timescale 1ns/1ns
module iox_commander (
  // Clock
  input  wire logic mclk,
  // Open-drain bus
  input  wire logic sdaWire,
  output logic      sclLevel,
  output logic      sdaPull
);
  logic [7:0] gotVal;
  event       got;
  initial begin
    sclLevel = 1'b1;
    sdaPull  = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Low 6, high 4: responder answers late, so data is read just before the fall
  task automatic bitOut(input logic b, output logic s);
    sdaPull <= ~b;
    cyc(4);
    sclLevel <= 1'b1;
    cyc(4);
    s = sdaWire;
    sclLevel <= 1'b0;
    cyc(2);
  endtask
  task automatic startCond;
    sdaPull  <= 1'b0;
    sclLevel <= 1'b1;
    cyc(4);
    sdaPull <= 1'b1;
    cyc(4);
    sclLevel <= 1'b0;
    cyc(2);
  endtask
  task automatic stopCond;
    sdaPull <= 1'b1;
    cyc(4);
    sclLevel <= 1'b1;
    cyc(4);
    sdaPull <= 1'b0;
    cyc(8);
  endtask
  task automatic shift(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) bitOut(v[i], r[i]);
  endtask
  task automatic sendByte(input logic [7:0] v);
    logic [8:0] r;
    shift({v, 1'b1}, r);
    gotVal = {7'h00, r[0]};
    ->got;
  endtask
  task automatic readByte;
    logic [8:0] r;
    shift(9'h1ff, r);
    gotVal = r[8:1];
    ->got;
  endtask
  task automatic sendPart(input logic [3:0] v);
    logic s;
    for (int i = 3; i >= 0; i--) bitOut(v[i], s);
  endtask
endmodule

/* File: bench/iox_expander_test.sv */
`timescale 1ns/1ns
module iox_expander_test;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       sclLevel;
  logic       sdaPull;
  logic       sdaWire;
  logic [2:0] pinAddressSelect = 3'h0;
  logic [7:0] pinExtLow = 8'h00;
  logic [7:0] expanderPinIn;
  logic [7:0] expanderPinOut;
  logic [7:0] expanderPinOe;
  logic [7:0] expanderPinStrongUp;
  logic       sdaOut;
  logic       sdaOe;
  logic       alertOut;
  logic       alertOe;
  logic [7:0] bQ[$];
  logic [7:0] pQ[$];
  logic [7:0] aQ[$];
  logic       armed = 1'b0;
  logic       watch = 1'b0;
  logic [7:0] cur = 8'hff;
  logic [7:0] r;
  int         seed = 7;
  int         miscompares = 0;
  int         num_checks = 0;
  always #4 mclk = ~mclk;
  assign sdaWire = ~(sdaPull | sdaOe);
  // Weak pull-up unless the latch or the outside world pulls low
  assign expanderPinIn = ~expanderPinOe & ~pinExtLow;
  iox_commander cmd (.mclk(mclk), .sdaWire(sdaWire), .sclLevel(sclLevel), .sdaPull(sdaPull));
  iox_expander uut (.mclk(mclk), .rst(rst), .sclIn(sclLevel), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .pinAddressSelect(pinAddressSelect), .expanderPinIn(expanderPinIn), .expanderPinOut(expanderPinOut),
    .expanderPinOe(expanderPinOe), .expanderPinStrongUp(expanderPinStrongUp), .alertOut(alertOut),
    .alertOe(alertOe));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (bQ.size() + pQ.size() + aQ.size() != 0) begin
      miscompares++;
      $display("BAD %0t expected results never seen", $time);
    end
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Mine: responder should answer; extra byte must be refused
  task automatic txn(input logic [7:0] a, input logic mine, input logic [7:0] d, input logic [7:0] extra);
    bQ.push_back({7'h00, ~mine});
    cmd.startCond;
    cmd.sendByte(a);
    if (mine && a[0]) begin
      bQ.push_back(d);
      cmd.readByte;
    end else if (!a[0]) begin
      bQ.push_back({7'h00, ~mine});
      if (mine) pQ.push_back(d);
      cmd.sendByte(d);
      bQ.push_back(8'h01);
      cmd.sendByte(extra);
    end
    cmd.stopCond;
  endtask
  always @(cmd.got) check(cmd.gotVal, bQ.size() ? bQ.pop_front() : 8'hxx);
  always @(expanderPinOut) if (armed) check(expanderPinOut, pQ.size() ? pQ.pop_front() : 8'hxx);
  always @(alertOe) if (watch) check({7'h00, alertOe}, aQ.size() ? aQ.pop_front() : 8'hxx);
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    $display("BAD %0t run did not finish", $time);
    stop_test;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cmd.cyc(6);
    armed = 1'b1;
    check(expanderPinOut, 8'hff);
    watch = 1'b1;
    r = 8'($random(seed)) | 8'h01;
    pinExtLow <= r;
    aQ.push_back(8'h01);
    cmd.cyc(20);
    txn(8'h00, 1'b0, 8'h55, 8'haa);
    txn(8'h7b, 1'b0, 8'h00, 8'h00);
    aQ.push_back(8'h00);
    txn(8'h71, 1'b1, ~r, 8'h00);
    pinExtLow <= r ^ 8'h80;
    aQ.push_back(8'h01);
    cmd.cyc(20);
    pinExtLow <= r;
    aQ.push_back(8'h00);
    cmd.cyc(20);
    watch = 1'b0;
    pinExtLow <= 8'h00;
    for (int s = 0; s < 8; s++) begin
      pinAddressSelect <= 3'(s);
      cmd.cyc(6);
      r = cur ^ (8'($random(seed)) | 8'h01);
      txn({4'h7, 3'(s), 1'b0}, 1'b1, r, ~r);
      cur = r;
    end
    bQ.push_back(8'h00);
    cmd.startCond;
    cmd.sendByte(8'h7e);
    cmd.sendPart(~cur[7:4]);
    cmd.stopCond;
    txn(8'h7f, 1'b1, cur, 8'h00);
    cmd.cyc(10);
    stop_test;
  end
endmodule
